// File: pkg/cear_cfg.svh
`ifndef CEAR_CFG_SVH
`define CEAR_CFG_SVH

// Map geometry
`define CEAR_ADDR_W 20
`define CEAR_DATA_W 8
`define CEAR_PHASE_W 12
`define CEAR_NUM_CH 8
`define CEAR_NUM_QUAD_CH 4

// Register offsets
`define CEAR_OFF_PAIR_EN 20'h30011
`define CEAR_OFF_ERR_FLAGS 20'h30012
`define CEAR_OFF_ERR_EN 20'h30013
`define CEAR_OFF_QB_ALARM 20'h30014
`define CEAR_OFF_UNUSED 20'h30015
`define CEAR_OFF_RATE 20'h30016

// Writes that stay legal while the map is locked
`define CEAR_OFF_LOCK_KEY0 20'h30000
`define CEAR_OFF_LOCK_KEY1 20'h30001
`define CEAR_OFF_SCRATCH 20'h30002

// Field positions
`define CEAR_BIT_FRAME_OFS 0
`define CEAR_BIT_LOCKED_WR 1
`define CEAR_RATE_A_LSB 0
`define CEAR_RATE_B_LSB 2

// Reset values
`define CEAR_RST_FLAGS 2'h0
`define CEAR_RST_EN 2'h0
`define CEAR_RST_PAIR_EN 4'h0
`define CEAR_RST_ALARM 4'h0
`define CEAR_RST_RATE 4'h0

// Largest tolerated receive skew, in bytes
`define CEAR_MAX_SKEW_BYTES 12'h011

`endif

// File: pkg/cear_pkg.sv
package cear_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [19:0] addr;
    logic [7:0] wdata;
  } cear_bus_req_t;

  typedef enum logic [1:0] {
    CEAR_RATE_STS12_48 = 2'h0,
    CEAR_RATE_STS3 = 2'h2
  } cear_rate_t;

  typedef struct packed {
    logic [1:0] quad_b;
    logic [1:0] quad_a;
  } cear_rate_pair_t;

endpackage

// File: core/cear_regs.sv
// How it works
// RULE1 - Flag frame offset when skew exceeds 17 bytes
// RULE2 - Receive skew is checked every cycle
// RULE3 - Error flags sticky, write one clears
// RULE4 - Locked map write elsewhere raises write error
// RULE5 - Enable bit 0 gates frame offset flag
// RULE6 - Enable bit 1 gates locked-write flag
// RULE7 - Quad B alarms read in bits 0-3
// RULE8 - Two-bit rate field per quad
// RULE9 - One alarm enable per channel pair
// RULE10 - Event output when enabled flag set
// RULE11 - Unused bits read zero, ignore writes
//
// Design decision made here: the plain strobed port.
`include "cear_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module cear_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire cear_pkg::cear_bus_req_t bus_req,
  output logic [7:0] rd_data,
  input wire logic map_unlocked,
  input wire logic [95:0] rx_phase,
  input wire logic [3:0] quad_b_alarm_raw,
  output logic [3:0] quad_b_alarm,
  output logic [1:0] quad_a_rate_select,
  output logic [1:0] quad_b_rate_select,
  output logic [3:0] pair_alarm_en,
  output logic err_event
);

  // Reset release
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  wire logic rst_int_n;
  assign rst_int_n = rst_sync_reg;

  // Address decode
  wire logic hit_pair_en;
  wire logic hit_flags;
  wire logic hit_en;
  wire logic hit_alarm;
  wire logic hit_rate;
  wire logic hit_key0;
  wire logic hit_key1;
  wire logic hit_scratch;

  assign hit_pair_en = bus_req.addr == `CEAR_OFF_PAIR_EN;
  assign hit_flags = bus_req.addr == `CEAR_OFF_ERR_FLAGS;
  assign hit_en = bus_req.addr == `CEAR_OFF_ERR_EN;
  assign hit_alarm = bus_req.addr == `CEAR_OFF_QB_ALARM;
  assign hit_rate = bus_req.addr == `CEAR_OFF_RATE;
  assign hit_key0 = bus_req.addr == `CEAR_OFF_LOCK_KEY0;
  assign hit_key1 = bus_req.addr == `CEAR_OFF_LOCK_KEY1;
  assign hit_scratch = bus_req.addr == `CEAR_OFF_SCRATCH;

  wire logic wr_pair_en;
  wire logic wr_flags;
  wire logic wr_en;
  wire logic wr_rate;

  assign wr_pair_en = bus_req.wr & hit_pair_en;
  assign wr_flags = bus_req.wr & hit_flags;
  assign wr_en = bus_req.wr & hit_en;
  assign wr_rate = bus_req.wr & hit_rate;

  // Receive skew: running min and max across all channels
  wire logic [11:0] ph [8];
  wire logic [11:0] run_min [8];
  wire logic [11:0] run_max [8];

  genvar g;
  generate
    for (g = 0; g < `CEAR_NUM_CH; g = g + 1) begin : g_ch
      assign ph[g] = rx_phase[g*`CEAR_PHASE_W +: `CEAR_PHASE_W];
      if (g == 0) begin : g_first
        assign run_min[g] = ph[g];
        assign run_max[g] = ph[g];
      end else begin : g_rest
        assign run_min[g] = (ph[g] < run_min[g-1]) ? ph[g] : run_min[g-1];
        assign run_max[g] = (ph[g] > run_max[g-1]) ? ph[g] : run_max[g-1];
      end
    end
  endgenerate

  // Registered once so the compare tree stays off the flag path
  logic [11:0] skew_reg;
  logic [11:0] skew_next;

  assign skew_next = run_max[`CEAR_NUM_CH-1] - run_min[`CEAR_NUM_CH-1];

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      skew_reg <= 12'h000;
    end else if (ce) begin
      skew_reg <= skew_next; // [RULE2]
    end
  end

  wire logic skew_err;
  assign skew_err = skew_reg > `CEAR_MAX_SKEW_BYTES; // [RULE1] [RULE2]

  // Any write into the map, ours or not, except to the two key offsets and scratch, counts while locked
  wire logic locked_wr;
  assign locked_wr = bus_req.wr & ~map_unlocked & ~hit_key0 & ~hit_key1
                     & ~hit_scratch; // [RULE4]

  // Error flags
  logic [1:0] flags_reg;
  logic [1:0] flags_next;
  wire logic [1:0] flag_set;
  wire logic [1:0] flag_clr;

  assign flag_set[`CEAR_BIT_FRAME_OFS] = skew_err; // [RULE1]
  assign flag_set[`CEAR_BIT_LOCKED_WR] = locked_wr; // [RULE4]
  assign flag_clr = wr_flags ? bus_req.wdata[1:0] : 2'h0;

  // A set in the clearing cycle survives the clear
  assign flags_next = (flags_reg & ~flag_clr) | flag_set; // [RULE3]

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      flags_reg <= `CEAR_RST_FLAGS;
    end else if (ce) begin
      flags_reg <= flags_next;
    end
  end

  // Error enables
  logic [1:0] en_reg;
  logic [1:0] en_next;

  assign en_next = wr_en ? bus_req.wdata[1:0] : en_reg; // [RULE5] [RULE6] [RULE11]

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      en_reg <= `CEAR_RST_EN;
    end else if (ce) begin
      en_reg <= en_next;
    end
  end

  // Event output
  logic event_reg;
  wire logic event_next;
  wire logic ofs_live;
  wire logic lwr_live;

  assign ofs_live = flags_next[`CEAR_BIT_FRAME_OFS] & en_next[`CEAR_BIT_FRAME_OFS]; // [RULE5]
  assign lwr_live = flags_next[`CEAR_BIT_LOCKED_WR] & en_next[`CEAR_BIT_LOCKED_WR]; // [RULE6]
  assign event_next = ofs_live | lwr_live; // [RULE10]

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      event_reg <= 1'b0;
    end else if (ce) begin
      event_reg <= event_next;
    end
  end

  assign err_event = event_reg;

  // Channel-pair alarm enables
  logic [3:0] pair_en_reg;
  logic [3:0] pair_en_next;

  assign pair_en_next = wr_pair_en ? bus_req.wdata[3:0] : pair_en_reg; // [RULE9]

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      pair_en_reg <= `CEAR_RST_PAIR_EN;
    end else if (ce) begin
      pair_en_reg <= pair_en_next;
    end
  end

  assign pair_alarm_en = pair_en_reg;

  // Quad B consolidated alarms, masked per pair
  logic [3:0] alarm_reg;
  wire logic [3:0] alarm_next;

  assign alarm_next = quad_b_alarm_raw & pair_en_reg; // [RULE7] [RULE9]

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      alarm_reg <= `CEAR_RST_ALARM;
    end else if (ce) begin
      alarm_reg <= alarm_next;
    end
  end

  assign quad_b_alarm = alarm_reg;

  // Rate select, one field per quad
  cear_pkg::cear_rate_pair_t rate_reg;
  cear_pkg::cear_rate_pair_t rate_next;

  // Undefined codes are kept as written; the quad logic decides
  assign rate_next = wr_rate ? bus_req.wdata[3:0] : rate_reg; // [RULE8]

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      rate_reg <= `CEAR_RST_RATE;
    end else if (ce) begin
      rate_reg <= rate_next;
    end
  end

  assign quad_a_rate_select = rate_reg.quad_a; // [RULE8]
  assign quad_b_rate_select = rate_reg.quad_b; // [RULE8]

  // Read mux, unused bits and unmapped addresses give zero
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    if (bus_req.rd) begin
      case (1'b1)
        hit_pair_en: rd_mux = {4'h0, pair_en_reg};
        hit_flags: rd_mux = {6'h00, flags_reg}; // [RULE3] [RULE11]
        hit_en: rd_mux = {6'h00, en_reg}; // [RULE11]
        hit_alarm: rd_mux = {4'h0, alarm_reg}; // [RULE7]
        hit_rate: rd_mux = {4'h0, rate_reg}; // [RULE11]
        default: rd_mux = 8'h00;
      endcase
    end
  end

  // Data stand only in the cycle after the strobe
  logic [7:0] rd_data_reg;

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      rd_data_reg <= 8'h00;
    end else if (ce) begin
      rd_data_reg <= rd_mux;
    end
  end

  assign rd_data = rd_data_reg;

endmodule

`default_nettype wire

// File: verification/cear_regs_chk.sv
`include "cear_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module cear_regs_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire cear_pkg::cear_bus_req_t bus_req,
  input wire logic [7:0] rd_data,
  input wire logic map_unlocked,
  input wire logic [95:0] rx_phase,
  input wire logic [3:0] quad_b_alarm_raw,
  input wire logic [3:0] quad_b_alarm,
  input wire logic [1:0] quad_a_rate_select,
  input wire logic [1:0] quad_b_rate_select,
  input wire logic [3:0] pair_alarm_en,
  input wire logic err_event
);
  logic [1:0] up_reg;
  logic [1:0] en_reg;
  logic [11:0] hi;
  logic [11:0] lo;
  wire run = up_reg == 2'h3 && ce;
  wire wr_rate = bus_req.wr && bus_req.addr == `CEAR_OFF_RATE;
  always_comb begin
    hi = 12'h000;
    lo = 12'hfff;
    for (int i = 0; i < 8; i++) begin
      if (rx_phase[12*i+:12] > hi) hi = rx_phase[12*i+:12];
      if (rx_phase[12*i+:12] < lo) lo = rx_phase[12*i+:12];
    end
  end
  // Internal reset lags rst_n by two edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) up_reg <= 2'h0;
    else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) en_reg <= 2'h0;
    else if (run && bus_req.wr && bus_req.addr == `CEAR_OFF_ERR_EN) en_reg <= bus_req.wdata[1:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_LOCK: assert property (run && wr_rate && !map_unlocked
    && en_reg[1] |=> err_event)
    else $error("no locked write event");
  AST_SKEW: assert property (run && en_reg[0]
    && hi - lo > `CEAR_MAX_SKEW_BYTES |-> ##2 err_event)
    else $error("no skew event");
  AST_QUIET: assert property (run && en_reg == 2'h0
    && $past(en_reg) == 2'h0 |-> !err_event)
    else $error("event while disabled");
  AST_RATE: assert property (run && wr_rate |=>
    quad_a_rate_select == $past(bus_req.wdata[1:0])
    && quad_b_rate_select == $past(bus_req.wdata[3:2]))
    else $error("rate not stored");
  AST_HOLD: assert property (run && !wr_rate |=>
    $stable({quad_a_rate_select, quad_b_rate_select}))
    else $error("rate moved");
  AST_QB: assert property (run && $past(run)
    && $stable(quad_b_alarm_raw) && $stable(pair_alarm_en)
    |-> quad_b_alarm == (quad_b_alarm_raw & pair_alarm_en))
    else $error("alarm mismatch");
  AST_UNUSED: assert property (run && bus_req.rd
    && bus_req.addr == `CEAR_OFF_UNUSED |=> rd_data == 8'h00)
    else $error("unused slot not zero");
  AST_EN_RD: assert property (run && bus_req.rd
    && bus_req.addr == `CEAR_OFF_ERR_EN |=> rd_data == {6'h00, $past(en_reg)})
    else $error("enable readback");
endmodule
bind cear_regs cear_regs_chk cear_regs_chk_inst (.clk, .rst_n, .ce, .bus_req, .rd_data,
  .map_unlocked, .rx_phase, .quad_b_alarm_raw, .quad_b_alarm, .quad_a_rate_select,
  .quad_b_rate_select, .pair_alarm_en, .err_event);
`default_nettype wire

// File: verification/tb_top.sv
`include "cear_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  typedef struct packed {logic [19:0] a; logic [7:0] d; logic [7:0] e;} cear_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic map_unlocked = 1'b1;
  logic [95:0] rx_phase = '0;
  logic [3:0] raw = 4'h0;
  logic [7:0] rd_data;
  logic [3:0] qb, pen;
  logic [1:0] ra, rb;
  logic err_event;
  cear_pkg::cear_bus_req_t q = '0;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  cear_row_t rows [8] = '{'{`CEAR_OFF_PAIR_EN, 8'hff, 8'h0f}, '{`CEAR_OFF_ERR_EN, 8'hff, 8'h03},
    '{`CEAR_OFF_RATE, 8'h02, 8'h02}, '{`CEAR_OFF_RATE, 8'h08, 8'h08},
    '{`CEAR_OFF_RATE, 8'hff, 8'h0f}, '{`CEAR_OFF_UNUSED, 8'hff, 8'h00},
    '{`CEAR_OFF_QB_ALARM, 8'hff, 8'h00}, '{20'h30020, 8'hff, 8'h00}};
  cear_regs cear_regs_inst (.clk, .rst_n, .ce, .bus_req(q), .rd_data, .map_unlocked, .rx_phase,
    .quad_b_alarm_raw(raw), .quad_b_alarm(qb), .quad_a_rate_select(ra),
    .quad_b_rate_select(rb), .pair_alarm_en(pen), .err_event);
  initial forever #4 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    q <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    q.wr <= 1'b0;
  endtask
  task automatic rc(input logic [19:0] a, input logic [7:0] e);
    @(posedge clk);
    q <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    q.rd <= 1'b0;
    // Data still hold the read value before this edge updates them
    @(posedge clk);
    chk(rd_data, e);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (rows[i]) rc(rows[i].a, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rc(rows[i].a, rows[i].e);
    end
    raw <= 4'ha;
    wr(`CEAR_OFF_PAIR_EN, 8'h06);
    rc(`CEAR_OFF_QB_ALARM, 8'h02);
    chk({pen, qb}, 8'h62);
    wr(`CEAR_OFF_ERR_EN, 8'h02);
    map_unlocked <= 1'b0;
    wr(`CEAR_OFF_LOCK_KEY0, 8'h11);
    wr(`CEAR_OFF_SCRATCH, 8'h22);
    rc(`CEAR_OFF_ERR_FLAGS, 8'h00);
    wr(`CEAR_OFF_RATE, 8'h02);
    rc(`CEAR_OFF_ERR_FLAGS, 8'h02);
    chk({7'h00, err_event}, 8'h01);
    chk({4'h0, rb, ra}, 8'h02);
    // Clearing while locked would itself set the flag again
    map_unlocked <= 1'b1;
    wr(`CEAR_OFF_ERR_FLAGS, 8'h01);
    rc(`CEAR_OFF_ERR_FLAGS, 8'h02);
    wr(`CEAR_OFF_ERR_FLAGS, 8'h02);
    rc(`CEAR_OFF_ERR_FLAGS, 8'h00);
    chk({7'h00, err_event}, 8'h00);
    wr(`CEAR_OFF_ERR_EN, 8'h00);
    rx_phase[95:84] <= 12'h011;
    repeat (4) @(posedge clk);
    rc(`CEAR_OFF_ERR_FLAGS, 8'h00);
    rx_phase[95:84] <= 12'h012;
    repeat (3) @(posedge clk);
    rc(`CEAR_OFF_ERR_FLAGS, 8'h01);
    chk({7'h00, err_event}, 8'h00);
    wr(`CEAR_OFF_ERR_EN, 8'h01);
    repeat (2) @(posedge clk);
    chk({7'h00, err_event}, 8'h01);
    rx_phase <= '0;
    wr(`CEAR_OFF_ERR_FLAGS, 8'h01);
    rc(`CEAR_OFF_ERR_FLAGS, 8'h00);
    rx_phase <= {{4{12'h100}}, 12'h0ed, {3{12'h100}}};
    repeat (3) @(posedge clk);
    rc(`CEAR_OFF_ERR_FLAGS, 8'h01);
    // Clock enable low must drop the write
    ce <= 1'b0;
    wr(`CEAR_OFF_RATE, 8'h0c);
    ce <= 1'b1;
    rc(`CEAR_OFF_RATE, 8'h02);
    // Reset in mid-run clears every output at once
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({pen, qb}, 8'h00);
    chk({3'h0, err_event, rb, ra}, 8'h00);
    chk(rd_data, 8'h00);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rc(`CEAR_OFF_ERR_EN, 8'h00);
    rc(`CEAR_OFF_RATE, 8'h00);
    conclude();
  end
endmodule
`default_nettype wire
